// >>> hw/dma_consts.svh
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH
// Function
// - master and slave controllers, slave cascaded
// - four passive channels grant off-board masters
// - active request raises master hold request
// - processors cleared before hold acknowledge
// - high byte strobed on shared lines
// - four-bit bank extends sixteen-bit address
// - refresh runs memory cycle, no data
// - transfer end drops hold, processor resumes
// - slave channel zero serves floppy only
// - slave hold drives master cascade request
// - cascade master arbitrates, acknowledge passes control
// - slave drop ripples to master drop
// - floppy cycles stretched two clock periods
// - free channels selectable active or passive
// - bus wait line stretches after T2/T3
// - interrupt under eight-bit owner swaps processors
// - DMA requests win bus first
// - bus returns to previous processor owner
// - controllers clocked at 4 MHz

// ==========================================================
// clocks
`define SYS_CLK_HZ   32'h0131_2D00
`define DMA_CLK_HZ   32'h003D_0900
`define DMA_DIV      (`SYS_CLK_HZ / `DMA_CLK_HZ)
`define DIV_W        3
`define DIV_LAST     3'(`DMA_DIV - 1)
`define DMA_CLK_HIGH 3'h2

// ==========================================================
// channels and widths
`define CH_REFRESH   2'h0
`define CH_MST_FREE  2'h2
`define CH_CASCADE   2'h3
`define CH_FLOPPY    2'h0
`define PASSIVE_MST  2'h0
`define FLOPPY_WAITS 2'h2
`define FIFO_WIDTH   8
`define FIFO_DEPTH   16
`define ADDR_W       16
`define N_BANK       8

`endif

// >>> hw/dma_pkg.sv
package dma_pkg;

    // ==========================================================
    // states
    typedef enum logic [1:0] {OWN_P8, OWN_P16, OWN_DMA} owner_type;
    typedef enum logic [1:0] {ARB_CPU, ARB_CLEAR, ARB_DMA} arb_type;
    typedef enum logic [3:0] {
        CY_IDLE, CY_WAIT_ACK, CY_ARM, CY_T1, CY_T2, CY_T3, CY_TW, CY_T4, CY_PASSIVE
    } cycle_type;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [2:0] mst_dreq;
        logic [3:0] slv_dreq;
        logic       irq;
        logic       p16_released;
        logic       p8_released;
        logic       to_p8;
        logic       to_p16;
        logic       bus_wait;
        logic [3:0] passive;
    } pins_type;

    typedef struct packed {
        logic memr;
        logic memw;
        logic ior;
        logic refresh;
    } bus_ctl_type;

    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] ad_hi;
        logic [7:0] lo;
        logic       stb;
        logic       oe;
    } addr_out_type;

endpackage

// >>> hw/dma_fifo.sv
`timescale 1ns/100ps
module dma_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // ==========================================================
    // handshake
    assign in_ready  = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // ==========================================================
    // pointers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ==========================================================
    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// >>> hw/dma_bus_arbitration.sv
`timescale 1ns/100ps
`include "dma_consts.svh"
module dma_bus_arbitration
    import dma_pkg::*;
(
    input  wire logic            SYS_CLK,
    input  wire logic            RESETN,
    input  wire logic [2:0]      MST_DREQ,
    input  wire logic [3:0]      SLV_DREQ,
    input  wire logic [3:0]      CHAN_PASSIVE,
    input  wire logic            IRQ,
    input  wire logic            P16_RELEASED,
    input  wire logic            P8_RELEASED,
    input  wire logic            TO_P8_REQ,
    input  wire logic            TO_P16_REQ,
    input  wire logic            BUS_WAIT_LINE,
    input  wire logic [7:0][3:0] BANK_FILE,
    input  wire logic [7:0]      DEV_DATA,
    input  wire logic            DEV_VALID,
    output logic                 DEV_READY,
    output logic                 DMA_CLK,
    output logic                 HOLD_REQ,
    output logic                 HOLD_ACK,
    output logic                 P16_HOLD,
    output logic                 P8_RELEASE_REQ,
    output logic [3:0]           MST_DACK,
    output logic [3:0]           SLV_DACK,
    output logic                 FLOPPY_READY,
    output addr_out_type         ADDR_OUT,
    output logic [7:0]           ADDRESS_LATCH,
    output bus_ctl_type          BUS_CTL,
    output logic [7:0]           DATA_OUT
);

    pins_type          pin_raw;
    pins_type          pin_meta;
    pins_type          pin;
    logic [`DIV_W-1:0] div_cnt;
    logic              dma_tick;
    logic              slave_hold;
    logic [1:0]        slave_ch;
    logic [2:0]        slv_pick;
    logic [2:0]        mst_pick;
    logic [3:0]        mst_req;
    cycle_type         state;
    logic [1:0]        cur_ch;
    logic              cur_req;
    logic              cascade;
    logic              refresh;
    logic              floppy;
    logic              passive;
    logic [2:0]        eff;
    logic [1:0]        fl_cnt;
    logic [`ADDR_W-1:0] addr [0:`N_BANK-1];
    logic              in_cyc;
    logic              xfer;
    logic              granted;
    logic [7:0]        fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    arb_type           arb;
    owner_type         owner;
    owner_type         prev_owner;

    // ==========================================================
    // fixed priority, lowest index first
    function automatic logic [2:0] pick(input logic [3:0] req);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (req[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    // ==========================================================
    // pin synchronisers
    assign pin_raw = '{
        mst_dreq:     MST_DREQ,
        slv_dreq:     SLV_DREQ,
        irq:          IRQ,
        p16_released: P16_RELEASED,
        p8_released:  P8_RELEASED,
        to_p8:        TO_P8_REQ,
        to_p16:       TO_P16_REQ,
        bus_wait:     BUS_WAIT_LINE,
        passive:      CHAN_PASSIVE
    };

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta <= '0;
            pin      <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin      <= pin_meta;
        end
    end

    // ==========================================================
    // controller clock
    assign dma_tick = div_cnt == `DIV_LAST;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt <= '0;
            DMA_CLK <= 1'b0;
        end else begin
            div_cnt <= dma_tick ? '0 : div_cnt + 1'b1;
            DMA_CLK <= div_cnt < `DMA_CLK_HIGH;
        end
    end

    // ==========================================================
    // slave controller
    assign slv_pick = pick(pin.slv_dreq);

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            slave_hold <= 1'b0;
            slave_ch   <= '0;
        end else if (dma_tick) begin
            if (slave_hold) begin
                slave_hold <= pin.slv_dreq[slave_ch];
            end else if (!(cascade && state != CY_IDLE)) begin
                slave_hold <= slv_pick[2];
                slave_ch   <= slv_pick[1:0];
            end
        end
    end

    // ==========================================================
    // channel decode
    // slave on cascade channel
    assign mst_req  = {slave_hold, pin.mst_dreq};
    assign mst_pick = pick(mst_req);
    assign cur_req  = mst_req[cur_ch];
    assign cascade  = cur_ch == `CH_CASCADE;
    assign eff      = {cascade, cascade ? slave_ch : cur_ch};
    assign refresh  = !cascade && cur_ch == `CH_REFRESH;
    assign floppy   = cascade && slave_ch == `CH_FLOPPY;
    assign passive  = cascade ? (slave_ch != `CH_FLOPPY && pin.passive[slave_ch])
                              : (cur_ch == `CH_MST_FREE && pin.passive[`PASSIVE_MST]);
    assign in_cyc   = state inside {CY_T1, CY_T2, CY_T3, CY_TW, CY_T4};
    assign xfer     = state inside {CY_T2, CY_T3, CY_TW};
    assign granted  = HOLD_ACK && state != CY_IDLE && state != CY_WAIT_ACK;
    assign fifo_pop = dma_tick && state == CY_T4 && !refresh;

    // ==========================================================
    // master cycle sequencer
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state    <= CY_IDLE;
            HOLD_REQ <= 1'b0;
            cur_ch   <= '0;
        end else if (dma_tick) begin
            unique case (state)
                CY_IDLE: begin
                    if (mst_pick[2]) begin
                        HOLD_REQ <= 1'b1;
                        cur_ch   <= mst_pick[1:0];
                        state    <= CY_WAIT_ACK;
                    end
                end
                CY_WAIT_ACK: begin
                    if (HOLD_ACK) begin
                        state <= CY_ARM;
                    end
                end
                CY_ARM: begin
                    if (!cur_req) begin
                        HOLD_REQ <= 1'b0;
                        state    <= CY_IDLE;
                    end else if (passive) begin
                        state <= CY_PASSIVE;
                    end else if (refresh || fifo_valid) begin
                        state <= CY_T1;
                    end
                end
                CY_T1: begin
                    state <= CY_T2;
                end
                CY_T2: begin
                    if (!pin.bus_wait) begin
                        state <= CY_T3;
                    end
                end
                CY_T3: begin
                    if (fl_cnt != '0 || pin.bus_wait) begin
                        state <= CY_TW;
                    end else begin
                        state <= CY_T4;
                    end
                end
                CY_TW: begin
                    if (fl_cnt == '0 && !pin.bus_wait) begin
                        state <= CY_T4;
                    end
                end
                CY_T4: begin
                    state <= CY_ARM;
                end
                CY_PASSIVE: begin
                    if (!cur_req) begin
                        HOLD_REQ <= 1'b0;
                        state    <= CY_IDLE;
                    end
                end
                default: begin
                    state <= CY_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // floppy ready counter
    // two added periods
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            fl_cnt <= '0;
        end else if (dma_tick) begin
            if (state == CY_T2) begin
                fl_cnt <= floppy ? `FLOPPY_WAITS : '0;
            end else if ((state == CY_T3 || state == CY_TW) && fl_cnt != '0) begin
                fl_cnt <= fl_cnt - 1'b1;
            end
        end
    end

    // ==========================================================
    // address counters
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < `N_BANK; i++) begin
                addr[i] <= '0;
            end
        end else if (dma_tick && state == CY_T4) begin
            addr[eff] <= addr[eff] + 1'b1;
        end
    end

    // ==========================================================
    // bus drive
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ADDR_OUT     <= '0;
            BUS_CTL      <= '0;
            MST_DACK     <= '0;
            SLV_DACK     <= '0;
            DATA_OUT     <= '0;
            FLOPPY_READY <= 1'b1;
        end else begin
            ADDR_OUT.oe    <= in_cyc;
            ADDR_OUT.stb   <= state == CY_T1;
            ADDR_OUT.ad_hi <= state == CY_T1 ? addr[eff][15:8] : '0;
            ADDR_OUT.lo    <= in_cyc ? addr[eff][7:0] : '0;
            ADDR_OUT.bank  <= in_cyc ? BANK_FILE[eff] : '0;
            BUS_CTL.memr    <= xfer && refresh;
            BUS_CTL.memw    <= xfer && !refresh;
            BUS_CTL.ior     <= xfer && !refresh;
            BUS_CTL.refresh <= in_cyc && refresh;
            MST_DACK <= granted ? 4'h1 << cur_ch : '0;
            SLV_DACK <= (granted && cascade) ? 4'h1 << slave_ch : '0;
            DATA_OUT     <= (xfer && !refresh) ? fifo_data : '0;
            FLOPPY_READY <= fl_cnt == '0;
        end
    end

    // ==========================================================
    // external high byte latch
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ADDRESS_LATCH <= '0;
        end else if (ADDR_OUT.stb) begin
            ADDRESS_LATCH <= ADDR_OUT.ad_hi;
        end
    end

    // ==========================================================
    // bus arbiter
    assign P16_HOLD       = owner != OWN_P16;
    assign P8_RELEASE_REQ = owner != OWN_P8;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            arb        <= ARB_CPU;
            owner      <= OWN_P16;
            prev_owner <= OWN_P16;
            HOLD_ACK   <= 1'b0;
        end else begin
            unique case (arb)
                ARB_CPU: begin
                    if (HOLD_REQ) begin
                        prev_owner <= owner;
                        owner      <= OWN_DMA;
                        arb        <= ARB_CLEAR;
                    end else if (owner == OWN_P8 && (pin.irq || pin.to_p16)) begin
                        owner <= OWN_P16;
                    end else if (owner == OWN_P16 && pin.to_p8) begin
                        owner <= OWN_P8;
                    end
                end
                ARB_CLEAR: begin
                    if (pin.p16_released && pin.p8_released) begin
                        HOLD_ACK <= 1'b1;
                        arb      <= ARB_DMA;
                    end
                end
                ARB_DMA: begin
                    if (!HOLD_REQ) begin
                        HOLD_ACK <= 1'b0;
                        owner    <= prev_owner;
                        arb      <= ARB_CPU;
                    end
                end
                default: begin
                    arb <= ARB_CPU;
                end
            endcase
        end
    end

    // ==========================================================
    // data buffer
    dma_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .resetn    (RESETN),
        .in_data   (DEV_DATA),
        .in_valid  (DEV_VALID),
        .in_ready  (DEV_READY),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );
endmodule

// >>> verif/dma_arb_properties.sv
`timescale 1ns/100ps
module dma_arb_properties
    import dma_pkg::*;
(
    input wire logic         SYS_CLK,
    input wire logic         RESETN,
    input wire logic         P16_RELEASED,
    input wire logic         P8_RELEASED,
    input wire logic         DMA_CLK,
    input wire logic         HOLD_REQ,
    input wire logic         HOLD_ACK,
    input wire logic         P16_HOLD,
    input wire logic         P8_RELEASE_REQ,
    input wire logic [3:0]   MST_DACK,
    input wire logic [3:0]   SLV_DACK,
    input wire logic         FLOPPY_READY,
    input wire addr_out_type ADDR_OUT,
    input wire logic [7:0]   ADDRESS_LATCH,
    input wire bus_ctl_type  BUS_CTL,
    input wire logic [7:0]   DATA_OUT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // ==========================================================
    // handshake and ownership
    a_ack_after_release: assert property (
        $rose(HOLD_ACK) |-> HOLD_REQ && $past(P16_RELEASED, 1) && $past(P8_RELEASED, 1))
        else $error("acknowledge before processors left");
    a_ack_needs_req: assert property (
        HOLD_ACK |-> HOLD_REQ || $past(HOLD_REQ))
        else $error("acknowledge without hold request");
    a_ack_release_req: assert property (
        $fell(HOLD_REQ) |=> !HOLD_ACK)
        else $error("acknowledge kept after hold drop");
    a_oe_owns_bus: assert property (
        ADDR_OUT.oe |-> HOLD_ACK && P16_HOLD && P8_RELEASE_REQ)
        else $error("address driven without bus");
    a_dack_onehot: assert property (
        $onehot0(MST_DACK) && $onehot0(SLV_DACK))
        else $error("acknowledge not one-hot");
    a_cascade_dack: assert property (
        (|SLV_DACK) |-> MST_DACK == 4'h8)
        else $error("slave grant without cascade acknowledge");

    // ==========================================================
    // cycle shape
    a_strobe_latch: assert property (
        ADDR_OUT.stb |=> ADDRESS_LATCH == $past(ADDR_OUT.ad_hi))
        else $error("high byte latch wrong");
    a_strobe_width: assert property (
        $rose(ADDR_OUT.stb) |-> ADDR_OUT.stb[*5] ##1 !ADDR_OUT.stb)
        else $error("address strobe not one T1 period");
    a_refresh_read: assert property (
        BUS_CTL.memr |-> BUS_CTL.refresh && MST_DACK == 4'h1)
        else $error("memory read outside refresh");
    a_refresh_no_data: assert property (
        BUS_CTL.refresh |-> !BUS_CTL.memw && !BUS_CTL.ior && DATA_OUT == 8'h00)
        else $error("refresh moved data");
    a_floppy_stretch: assert property (
        $fell(FLOPPY_READY) |-> SLV_DACK[0] ##0 (!FLOPPY_READY)[*8])
        else $error("floppy stretch too short");
    a_dma_clock_ratio: assert property (
        $rose(DMA_CLK) |=> DMA_CLK ##1 (!DMA_CLK)[*3] ##1 DMA_CLK)
        else $error("dma clock not high 2 of 5");
endmodule

bind dma_bus_arbitration dma_arb_properties dma_arb_properties_i (
    .SYS_CLK, .RESETN, .P16_RELEASED, .P8_RELEASED, .DMA_CLK, .HOLD_REQ, .HOLD_ACK,
    .P16_HOLD, .P8_RELEASE_REQ, .MST_DACK, .SLV_DACK, .FLOPPY_READY, .ADDR_OUT,
    .ADDRESS_LATCH, .BUS_CTL, .DATA_OUT
);

// >>> verif/cpu_pair_model.sv
`timescale 1ns/100ps
module cpu_pair_model (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic slow,
    input  wire logic p16_hold,
    input  wire logic p8_release_req,
    output logic      p16_released,
    output logic      p8_released
);
    int wait16;
    int wait8;

    // ==========================================================
    // processors leave the bus promptly or slowly
    // release before acknowledge
    always @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            wait16 <= 0;
            wait8 <= 0;
            p16_released <= 1'b0;
            p8_released <= 1'b0;
        end else begin
            wait16 <= p16_hold ? (wait16 < 50 ? wait16 + 1 : wait16) : 0;
            wait8 <= p8_release_req ? (wait8 < 50 ? wait8 + 1 : wait8) : 0;
            p16_released <= p16_hold && wait16 >= (slow ? 7 : 0);
            p8_released <= p8_release_req && wait8 >= (slow ? 5 : 0);
        end
    end
endmodule

// >>> verif/dma_bus_arbitration_test.sv
`timescale 1ns/100ps
module dma_bus_arbitration_test;
    import dma_pkg::*;

    logic            sys_clk, resetn, irq, p16_released, p8_released, to_p8_req, to_p16_req;
    logic            bus_wait_line, dev_valid, dev_ready, dma_clk, hold_req, hold_ack;
    logic            p16_hold, p8_release_req, floppy_ready, slow, xfer_prev;
    bit              stb_prev;
    logic [2:0]      mst_dreq;
    logic [3:0]      slv_dreq, chan_passive, mst_dack, slv_dack;
    logic [7:0][3:0] bank_file;
    logic [7:0]      dev_data, address_latch, data_out, held;
    addr_out_type    addr_out;
    bus_ctl_type     bus_ctl;
    logic [7:0]      exp_q[$];
    int              fails, samples_checked, seed, cycles, stb_count, low_count, wait_en, idx;
    int              last_addr[8];
    bit              seen[8];
    int              rs[7] = '{1, 0, 1, 1, 1, 0, 1};
    int              rc[7] = '{0, 2, 1, 2, 3, 2, 1};
    int              rp[7] = '{0, 1, 1, 1, 1, 0, 0};
    int              rn[7] = '{3, 0, 0, 0, 0, 2, 2};
    int              rw[7] = '{0, 0, 0, 0, 0, 1, 1};

    dma_bus_arbitration dma_bus_arbitration_i (
        .SYS_CLK(sys_clk), .RESETN(resetn), .MST_DREQ(mst_dreq), .SLV_DREQ(slv_dreq),
        .CHAN_PASSIVE(chan_passive), .IRQ(irq), .P16_RELEASED(p16_released),
        .P8_RELEASED(p8_released), .TO_P8_REQ(to_p8_req), .TO_P16_REQ(to_p16_req),
        .BUS_WAIT_LINE(bus_wait_line), .BANK_FILE(bank_file), .DEV_DATA(dev_data),
        .DEV_VALID(dev_valid), .DEV_READY(dev_ready), .DMA_CLK(dma_clk), .HOLD_REQ(hold_req),
        .HOLD_ACK(hold_ack), .P16_HOLD(p16_hold), .P8_RELEASE_REQ(p8_release_req),
        .MST_DACK(mst_dack), .SLV_DACK(slv_dack), .FLOPPY_READY(floppy_ready),
        .ADDR_OUT(addr_out), .ADDRESS_LATCH(address_latch), .BUS_CTL(bus_ctl),
        .DATA_OUT(data_out)
    );

    cpu_pair_model cpu_pair_model_i (
        .clk(sys_clk), .resetn(resetn), .slow(slow), .p16_hold(p16_hold),
        .p8_release_req(p8_release_req), .p16_released(p16_released),
        .p8_released(p8_released)
    );

    // ==========================================================
    // verdict and comparison
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic int which(input logic [3:0] v);
        for (int i = 0; i < 4; i++)
            if (v[i] === 1'b1)
                return i;
        return 0;
    endfunction

    // ==========================================================
    // clock and monitor
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            print_verdict;
        end
    end

    always @(negedge sys_clk) begin
        bus_wait_line <= (wait_en != 0) && (($random(seed) & 3) == 0);
        idx = (|slv_dack) ? 4 + which(slv_dack) : which(mst_dack);
        if (addr_out.stb === 1'b1 && !stb_prev) begin
            stb_count++;
            check(addr_out.bank, bank_file[idx], "bank field");
            if (seen[idx]) check({addr_out.ad_hi, addr_out.lo}, 16'(last_addr[idx] + 1), "address");
            last_addr[idx] = {addr_out.ad_hi, addr_out.lo};
            seen[idx] = 1'b1;
        end
        stb_prev = addr_out.stb === 1'b1;
        if (bus_ctl.memw === 1'b1 || bus_ctl.ior === 1'b1)
            held = data_out;
        else if (xfer_prev)
            check(held, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hffff, "data");
        xfer_prev = bus_ctl.memw === 1'b1 || bus_ctl.ior === 1'b1;
        if (floppy_ready === 1'b0) begin
            low_count++;
        end else if (low_count > 0) begin
            if (wait_en == 0) check(low_count, 10, "floppy stretch");
            low_count = 0;
        end
    end

    // ==========================================================
    // drivers
    task automatic push(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            dev_valid = 1'b1;
            dev_data = 8'($random(seed));
            while (dev_ready !== 1'b1) @(negedge sys_clk);
            exp_q.push_back(dev_data);
            @(posedge sys_clk);
        end
        @(negedge sys_clk);
        dev_valid = 1'b0;
    endtask

    task automatic wait_hold(input logic on_ack, input logic v);
        for (int k = 0; k < 400 && (on_ack ? hold_ack : hold_req) !== v; k++)
            @(negedge sys_clk);
        check(on_ack ? hold_ack : hold_req, v, "hold handshake");
    endtask

    task automatic run(input int slv, input int ch, input int pas, input int nb, input int wt);
        logic [1:0] own;
        int         need;
        int         base;
        own = {p16_hold, p8_release_req};
        chan_passive = pas ? (slv ? 4'(1 << ch) : 4'h1) : 4'h0;
        push(nb);
        wait_en = wt;
        slow = 1'($random(seed));
        need = pas ? 0 : (exp_q.size() > 0 ? exp_q.size() : 2);
        base = stb_count;
        if (slv) slv_dreq = 4'(1 << ch);
        else mst_dreq = 3'(1 << ch);
        wait_hold(1'b1, 1'b1);
        repeat (15) @(negedge sys_clk);
        check(mst_dack, slv ? 4'h8 : 4'(1 << ch), "master grant");
        check(slv_dack, slv ? 4'(1 << ch) : 4'h0, "slave grant");
        if (pas) check(addr_out.oe, 1'b0, "passive channel drives");
        if (pas) check(bus_ctl, 4'h0, "passive control released");
        for (int k = 0; k < 3000 && stb_count - base < need; k++) @(negedge sys_clk);
        check(stb_count - base >= need, 1'b1, "cycles run");
        mst_dreq = 3'h0;
        slv_dreq = 4'h0;
        wait_hold(1'b0, 1'b0);
        repeat (3) @(negedge sys_clk);
        check(hold_ack, 1'b0, "acknowledge released");
        check(exp_q.size(), 0, "fifo drained");
        repeat (10) @(negedge sys_clk);
        check({p16_hold, p8_release_req}, own, "owner restored");
        chan_passive = 4'h0;
        $display("test done: slave %0d channel %0d passive %0d", slv, ch, pas);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        seed = 10393;
        {resetn, irq, to_p8_req, to_p16_req, dev_valid, slow, xfer_prev} = '0;
        {mst_dreq, slv_dreq, chan_passive, dev_data, bus_wait_line} = '0;
        for (int i = 0; i < 8; i++) bank_file[i] = 4'($random(seed));
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        check({hold_req, hold_ack, floppy_ready, p8_release_req, p16_hold, dev_ready},
              6'b001101, "reset state");
        to_p8_req = 1'b1;
        repeat (6) @(negedge sys_clk);
        to_p8_req = 1'b0;
        check({p16_hold, p8_release_req}, 2'b10, "eight-bit owner");
        run(0, 0, 0, 0, 0);
        irq = 1'b1;
        repeat (6) @(negedge sys_clk);
        irq = 1'b0;
        check({p16_hold, p8_release_req}, 2'b01, "interrupt swap");
        to_p8_req = 1'b1;
        repeat (6) @(negedge sys_clk);
        {to_p8_req, to_p16_req} = 2'b01;
        repeat (6) @(negedge sys_clk);
        to_p16_req = 1'b0;
        check({p16_hold, p8_release_req}, 2'b01, "handback");
        push(16);
        check(dev_ready, 1'b0, "fifo full");
        run(0, 1, 0, 0, 1);
        for (int r = 0; r < 7; r++) run(rs[r], rc[r], rp[r], rn[r], rw[r]);
        print_verdict;
    end
endmodule
